// File: pmtr_map.svh
// pmtr_map.svh: constants for the program memory and table read block
// assumes one instruction cycle per clock and a sampled serial clock pin
//
// Behaviour
// (RULE1) program store holds 32K words of 16 bits, fetched at the program counter
// (RULE2) after reset the program counter starts at address zero
// (RULE3) code, table data and vectors share the store; any word is table-readable
// (RULE4) table address is the low and high table pointers combined
// (RULE5) table read writes the word's low byte into the operand register
// (RULE6) table read writes the word's high byte into the table high latch
// (RULE7) normal form only for sector 0 destinations; other sectors need extended form
// (RULE8) normal form: low pointer is offset into page chosen by high pointer
// (RULE9) every table read, normal or extended, takes two instruction cycles
// (RULE10) software can read and write the table high latch
// (RULE11) programming data moves both ways on one pin; tool drives the clock
// (RULE12) serial interface programs both program store and EEPROM data memory
// (RULE13) emulation variant: shared pin functions off; data two-way, clock input
// (RULE14) debug pins still serve as serial programming data and clock pins
// (RULE15) table address is 15 bits; high pointer bits above are ignored
// (RULE16) table read or program counter low byte write inserts a dummy fetch
`ifndef PMTR_MAP_SVH
`define PMTR_MAP_SVH
`define PMTR_ADDR_W 15
`define PMTR_DEPTH 32768
`define PMTR_RESET_VECTOR 15'h0000
`define PMTR_SECTOR0 1'h0
`define PMTR_TPH_USED 6:0
`define PMTR_SER_HDR 6'h11
`define PMTR_SER_LAST 6'h21
`define PMTR_SER_RW 32
`define PMTR_SER_TGT 31
`define PMTR_SER_ADDR 30:16
`define PMTR_SER_DATA 15:0
`define PMTR_DEST_SECTOR 8
`define PMTR_PC_PAGE 14:8
`define PMTR_BYTE_LO 7:0
`define PMTR_BYTE_HI 15:8
`define PMTR_HDR_RW 16
`define PMTR_HDR_TGT 15
`define PMTR_HDR_ADDR 14:0
`endif

// File: pmtr_pkg.sv
// pmtr_pkg.sv: types for the program memory and table read block
// assumes nothing beyond the constants header
package pmtr_pkg;
  typedef enum logic [2:0] {
    PMTR_OP_NOP = 3'h0,
    PMTR_OP_WR_TPL = 3'h1,
    PMTR_OP_WR_TPH = 3'h2,
    PMTR_OP_WR_TABLE_HIGH_LATCH = 3'h3,
    PMTR_OP_TABLE_READ_INSTR = 3'h4,
    PMTR_OP_EXTENDED_TABLE_READ_INSTR = 3'h5,
    PMTR_OP_WR_PCL = 3'h6
  } pmtr_op_e;
  typedef struct packed {
    logic valid;
    pmtr_op_e op;
    logic [7:0] data;
    logic [8:0] dest;
  } pmtr_cmd_s;
  typedef struct packed {
    logic valid;
    logic [14:0] pc;
    logic [15:0] word;
  } pmtr_fetch_s;
  typedef struct packed {
    logic valid;
    logic [8:0] dest;
    logic [7:0] data;
  } pmtr_wb_s;
  typedef struct packed {
    logic valid;
    logic [14:0] addr;
    logic [7:0] data;
  } pmtr_ee_s;
  typedef enum logic [2:0] {
    PMTR_ST_RUN = 3'b001,
    PMTR_ST_DUMMY = 3'b010,
    PMTR_ST_TBL = 3'b100
  } pmtr_state_e;
endpackage : pmtr_pkg

// File: pmtr_sync.sv
// pmtr_sync.sv: three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin level on i_pin
`timescale 1ns/1ps
`default_nettype none
module pmtr_sync (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;
  always_comb begin
    next_level = (s2 == s3) ? s3 : o_level;
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
      o_level <= 1'h0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      o_level <= next_level;
    end
  end
endmodule : pmtr_sync
`default_nettype wire

// File: pmtr_top.sv
// pmtr_top.sv: program store, fetch counter, table read and serial programming port
// assumes the core issues one command per clock and honours o_busy
`timescale 1ns/1ps
`default_nettype none
`include "pmtr_map.svh"
module pmtr_top (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire pmtr_pkg::pmtr_cmd_s i_cmd,
  input wire logic i_emulation_variant,
  input wire logic i_prog_enable,
  input wire logic i_prog_serial_clock,
  input wire logic i_prog_serial_data,
  input wire logic [7:0] i_eeprom_rdata,
  output logic o_prog_serial_data,
  output logic o_prog_serial_data_oe,
  output var pmtr_pkg::pmtr_fetch_s o_fetch,
  output var pmtr_pkg::pmtr_wb_s o_wb,
  output var pmtr_pkg::pmtr_ee_s o_eeprom_wr,
  output logic [7:0] o_table_high_latch,
  output logic [7:0] o_table_pointer_low,
  output logic [7:0] o_table_pointer_high,
  output logic o_busy,
  output logic o_illegal,
  output logic o_shared_function_off
);
  import pmtr_pkg::*;

  logic [15:0] mem [`PMTR_DEPTH];
  pmtr_state_e state;
  pmtr_state_e next_state;
  logic [14:0] pc;
  logic [14:0] next_pc;
  logic [7:0] next_tpl;
  logic [7:0] next_tph;
  logic [7:0] next_table_high_latch;
  logic [8:0] tbl_dest;
  logic [8:0] next_tbl_dest;
  pmtr_fetch_s next_fetch;
  pmtr_wb_s next_wb;
  logic next_busy;
  logic next_illegal;
  logic [14:0] tbl_addr;
  logic [15:0] tbl_word;

  // (RULE4) (RULE8) (RULE15) page from high pointer, offset from low
  assign tbl_addr = {o_table_pointer_high[`PMTR_TPH_USED], o_table_pointer_low};
  // (RULE3) any location readable
  assign tbl_word = mem[tbl_addr];

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_tpl = o_table_pointer_low;
    next_tph = o_table_pointer_high;
    next_table_high_latch = o_table_high_latch;
    next_tbl_dest = tbl_dest;
    next_wb = '0;
    next_illegal = 1'h0;
    next_busy = 1'h0;
    // (RULE1) fetch at program counter
    next_fetch.valid = 1'h1;
    next_fetch.pc = pc;
    next_fetch.word = mem[pc];
    case (state)
      PMTR_ST_RUN: begin
        next_pc = pc + 15'h0001;
        if (i_cmd.valid) begin
          case (i_cmd.op)
            PMTR_OP_WR_TPL: next_tpl = i_cmd.data;
            PMTR_OP_WR_TPH: next_tph = i_cmd.data;
            // (RULE10) latch software write
            PMTR_OP_WR_TABLE_HIGH_LATCH: next_table_high_latch = i_cmd.data;
            PMTR_OP_TABLE_READ_INSTR, PMTR_OP_EXTENDED_TABLE_READ_INSTR: begin
              // (RULE7) normal form only to sector 0
              if (i_cmd.op == PMTR_OP_TABLE_READ_INSTR &&
                  i_cmd.dest[`PMTR_DEST_SECTOR] != `PMTR_SECTOR0) begin
                next_illegal = 1'h1;
              end else begin
                // (RULE9) (RULE16) two cycles, dummy fetch
                next_state = PMTR_ST_TBL;
                next_tbl_dest = i_cmd.dest;
                next_busy = 1'h1;
                next_fetch.valid = 1'h0;
                next_pc = pc;
              end
            end
            PMTR_OP_WR_PCL: begin
              // (RULE16) pcl jump costs a dummy
              next_pc = {pc[`PMTR_PC_PAGE], i_cmd.data};
              next_state = PMTR_ST_DUMMY;
              next_busy = 1'h1;
              next_fetch.valid = 1'h0;
            end
            default: next_illegal = 1'h0;
          endcase
        end
      end
      PMTR_ST_TBL: begin
        // (RULE5) (RULE6) bytes to operand and latch
        next_wb.valid = 1'h1;
        next_wb.dest = tbl_dest;
        next_wb.data = tbl_word[`PMTR_BYTE_LO];
        next_table_high_latch = tbl_word[`PMTR_BYTE_HI];
        next_pc = pc + 15'h0001;
        next_state = PMTR_ST_RUN;
      end
      PMTR_ST_DUMMY: begin
        next_pc = pc + 15'h0001;
        next_state = PMTR_ST_RUN;
      end
      default: begin
        next_state = PMTR_ST_RUN;
        next_fetch.valid = 1'h0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= PMTR_ST_RUN;
      // (RULE2) start at reset vector
      pc <= `PMTR_RESET_VECTOR;
      o_table_pointer_low <= 8'h00;
      o_table_pointer_high <= 8'h00;
      o_table_high_latch <= 8'h00;
      tbl_dest <= 9'h000;
      o_fetch <= '0;
      o_wb <= '0;
      o_busy <= 1'h0;
      o_illegal <= 1'h0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      o_table_pointer_low <= next_tpl;
      o_table_pointer_high <= next_tph;
      o_table_high_latch <= next_table_high_latch;
      tbl_dest <= next_tbl_dest;
      o_fetch <= next_fetch;
      o_wb <= next_wb;
      o_busy <= next_busy;
      o_illegal <= next_illegal;
    end
  end

  // serial programming port
  logic sclk;
  logic sclk_d;
  logic [5:0] bit_cnt;
  logic [5:0] next_bit_cnt;
  logic [32:0] shreg;
  logic [32:0] next_shreg;
  logic [15:0] out_word;
  logic [15:0] next_out_word;
  logic next_sdo;
  logic next_sdo_oe;
  pmtr_ee_s next_ee;
  logic mem_we;
  logic [14:0] mem_waddr;
  logic [15:0] mem_wdata;

  // (RULE11) (RULE14) same pins serve programming and debug
  pmtr_sync u_sync_clk (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_pin(i_prog_serial_clock),
    .o_level(sclk)
  );
  logic sdi;
  pmtr_sync u_sync_dat (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_pin(i_prog_serial_data),
    .o_level(sdi)
  );

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_out_word = out_word;
    next_sdo = o_prog_serial_data;
    next_sdo_oe = o_prog_serial_data_oe;
    next_ee = '0;
    mem_we = 1'h0;
    mem_waddr = shreg[`PMTR_SER_ADDR];
    mem_wdata = shreg[`PMTR_SER_DATA];
    if (!i_prog_enable) begin
      next_bit_cnt = 6'h00;
      next_sdo_oe = 1'h0;
      next_sdo = 1'h0;
    end else if (sclk && !sclk_d && bit_cnt != `PMTR_SER_LAST) begin
      next_shreg = {shreg[31:0], sdi};
      next_bit_cnt = bit_cnt + 6'h01;
    end else if (!sclk && sclk_d && next_sdo_oe) begin
      // (RULE11) read data driven msb first
      next_sdo = out_word[15];
      next_out_word = {out_word[14:0], 1'h0};
    end else if (bit_cnt == `PMTR_SER_HDR && !o_prog_serial_data_oe && shreg[`PMTR_HDR_RW]) begin
      // (RULE12) read either store
      next_out_word = shreg[`PMTR_HDR_TGT] ? {8'h00, i_eeprom_rdata} : mem[shreg[`PMTR_HDR_ADDR]];
      next_sdo_oe = 1'h1;
    end else if (bit_cnt == `PMTR_SER_LAST && !shreg[`PMTR_SER_RW]) begin
      // (RULE12) write either store
      mem_we = !shreg[`PMTR_SER_TGT];
      next_ee.valid = shreg[`PMTR_SER_TGT];
      next_ee.addr = shreg[`PMTR_SER_ADDR];
      next_ee.data = shreg[`PMTR_BYTE_LO];
      next_bit_cnt = 6'h00;
    end else if (bit_cnt == `PMTR_SER_LAST) begin
      next_bit_cnt = 6'h00;
      next_sdo_oe = 1'h0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_d <= 1'h0;
      bit_cnt <= 6'h00;
      shreg <= '0;
      out_word <= 16'h0000;
      o_prog_serial_data <= 1'h0;
      o_prog_serial_data_oe <= 1'h0;
      o_eeprom_wr <= '0;
      o_shared_function_off <= 1'h0;
    end else begin
      sclk_d <= sclk;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      out_word <= next_out_word;
      o_prog_serial_data <= next_sdo;
      o_prog_serial_data_oe <= next_sdo_oe;
      o_eeprom_wr <= next_ee;
      // (RULE13) emulation variant frees shared functions
      o_shared_function_off <= i_emulation_variant;
    end
  end

  // store written only by the programming port
  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  property p_tbl_two;
    i_cmd.valid && i_cmd.op == PMTR_OP_EXTENDED_TABLE_READ_INSTR && state == PMTR_ST_RUN |-> ##2 o_wb.valid;
  endproperty
  a_tbl_two: assert property (p_tbl_two) else $error("table read not done in two cycles"); // RULE9
  property p_low_byte;
    state == PMTR_ST_TBL |=> o_wb.data == $past(tbl_word[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte wrong"); // RULE5
  property p_high_byte;
    state == PMTR_ST_TBL |=> o_table_high_latch == $past(tbl_word[15:8]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("latch high byte wrong"); // RULE6
  property p_sector;
    i_cmd.valid && i_cmd.op == PMTR_OP_TABLE_READ_INSTR && i_cmd.dest[8] && state == PMTR_ST_RUN
      |=> o_illegal ##1 !o_wb.valid;
  endproperty
  a_sector: assert property (p_sector) else $error("normal form to other sector"); // RULE7
  property p_dummy;
    state == PMTR_ST_RUN && next_state != PMTR_ST_RUN |=> !o_fetch.valid;
  endproperty
  a_dummy: assert property (p_dummy) else $error("missing dummy fetch"); // RULE16
  property p_table_high_latch_wr;
    i_cmd.valid && i_cmd.op == PMTR_OP_WR_TABLE_HIGH_LATCH && state == PMTR_ST_RUN
      |=> o_table_high_latch == $past(i_cmd.data);
  endproperty
  a_table_high_latch_wr: assert property (p_table_high_latch_wr) else $error("latch write lost"); // RULE10
  property p_addr;
    o_wb.valid |->
      o_wb.data == $past(mem[{o_table_pointer_high[6:0], o_table_pointer_low}][7:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("table address wrong"); // RULE4
  property p_pcl;
    i_cmd.valid && i_cmd.op == PMTR_OP_WR_PCL && state == PMTR_ST_RUN
      |=> ##1 o_fetch.valid && o_fetch.pc[7:0] == $past(i_cmd.data, 2);
  endproperty
  a_pcl: assert property (p_pcl) else $error("pcl jump wrong"); // RULE16
  property p_oe_off;
    !i_prog_enable |=> !o_prog_serial_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data driven outside programming"); // RULE11
endmodule : pmtr_top
`default_nettype wire

// File: pmtr_tool.sv
// pmtr_tool.sv: serial programming tool model on the link pins
// assumes the device drives the data pin only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module pmtr_tool (
  input wire logic i_dev_data,
  input wire logic i_dev_oe,
  output logic o_clock,
  output logic o_data
);
  logic drv = 1'h0;
  logic last = 1'h0;
  assign o_data = i_dev_oe ? i_dev_data : (drv ? last : ~last);
  initial o_clock = 1'h0;
  task automatic frame(input logic [32:0] f, output logic [15:0] rd);
    rd = 16'h0000;
    drv = 1'h1;
    for (int i = 32; i >= 0; i--) begin
      if (f[32] && i < 16) drv = 1'h0;
      else last = f[i];
      #62.5 o_clock = 1'h1;
      if (!drv) rd = {rd[14:0], o_data};
      #62.5 o_clock = 1'h0;
    end
    drv = 1'h0;
    #500;
  endtask : frame
endmodule : pmtr_tool
`default_nettype wire

// File: pmtr_top_tb.sv
// pmtr_top_tb.sv: self-checking bench for the table read block
// assumes pmtr_tool stands on the serial programming pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pmtr_top_tb;
  import pmtr_pkg::*;
  logic i_clock = 1'h0;
  logic i_reset_n = 1'h0;
  pmtr_cmd_s cmd_q = '0;
  logic emu = 1'h0;
  logic pen = 1'h0;
  logic [7:0] ee_rd = 8'h00;
  logic sclk, sdat, d_out, d_oe, busy, illegal, shared_off;
  pmtr_fetch_s fetch;
  pmtr_wb_s wb;
  pmtr_ee_s eew, ee_q;
  logic [7:0] tbl_hi, tp_lo, tp_hi, lo, hi;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] mem [logic [14:0]];
  always #5 i_clock = ~i_clock;
  pmtr_top DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cmd(cmd_q),
    .i_emulation_variant(emu), .i_prog_enable(pen), .i_prog_serial_clock(sclk),
    .i_prog_serial_data(sdat), .i_eeprom_rdata(ee_rd), .o_prog_serial_data(d_out),
    .o_prog_serial_data_oe(d_oe), .o_fetch(fetch), .o_wb(wb), .o_eeprom_wr(eew),
    .o_table_high_latch(tbl_hi), .o_table_pointer_low(tp_lo),
    .o_table_pointer_high(tp_hi), .o_busy(busy), .o_illegal(illegal),
    .o_shared_function_off(shared_off));
  pmtr_tool TOOL (.i_dev_data(d_out), .i_dev_oe(d_oe), .o_clock(sclk), .o_data(sdat));
  always @(negedge i_clock) if (eew.valid === 1'h1) ee_q <= eew;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  function automatic logic [15:0] exp_word(input logic [7:0] l, input logic [7:0] h);
    return mem[{h[6:0], l}];
  endfunction : exp_word
  task automatic cmd(input pmtr_op_e op, input logic [8:0] dest, input logic [7:0] d);
    @(negedge i_clock);
    cmd_q <= '{1'h1, op, d, dest};
    @(negedge i_clock);
    cmd_q <= '0;
  endtask : cmd
  task automatic tread(input pmtr_op_e op, input logic [8:0] dest);
    logic [15:0] w;
    int n;
    w = exp_word(lo, hi);
    n = 0;
    cmd(op, dest, 8'h00);
    `CHK("busy", 1'h1, busy)
    `CHK("fetch valid", 1'h0, fetch.valid)
    while (wb.valid !== 1'h1 && n < 3) begin
      @(negedge i_clock);
      n++;
    end
    `CHK("wb valid", 1'h1, wb.valid)
    `CHK("wb data", w[7:0], wb.data)
    `CHK("wb dest", dest, wb.dest)
    `CHK("latch", w[15:8], tbl_hi)
  endtask : tread
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    logic [15:0] rd;
    logic [15:0] d;
    logic [14:0] a;
    void'($urandom(45317));
    repeat (4) @(negedge i_clock);
    i_reset_n = 1'h1;
    @(negedge i_clock);
    `CHK("reset pc", 15'h0000, fetch.pc)
    `CHK("shared on", 1'h0, shared_off)
    emu = 1'h1;
    pen = 1'h1;
    @(negedge i_clock);
    `CHK("shared off", 1'h1, shared_off)
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 15'h7006 : (i == 1) ? 15'h7fff : (i == 2) ? 15'h0000 : 15'($urandom);
      d = 16'($urandom);
      mem[a] = d;
      TOOL.frame({1'h0, 1'h0, a, d}, rd);
      lo = a[7:0];
      hi = {1'($urandom), a[14:8]};
      cmd(PMTR_OP_WR_TPL, 9'h000, lo);
      cmd(PMTR_OP_WR_TPH, 9'h000, hi);
      `CHK("ptr low", lo, tp_lo)
      `CHK("ptr high", hi, tp_hi)
      tread(i[0] ? PMTR_OP_EXTENDED_TABLE_READ_INSTR : PMTR_OP_TABLE_READ_INSTR, {i[0] & 1'($urandom), 8'($urandom)});
      TOOL.frame({1'h1, 1'h0, a, 16'h0000}, rd);
      `CHK("serial read", d, rd)
    end
    cmd(PMTR_OP_TABLE_READ_INSTR, {1'h1, 8'($urandom)}, 8'h00);
    `CHK("illegal", 1'h1, illegal)
    @(negedge i_clock);
    `CHK("no wb", 1'h0, wb.valid)
    d = 16'($urandom);
    cmd(PMTR_OP_WR_TABLE_HIGH_LATCH, 9'h000, d[7:0]);
    `CHK("latch write", d[7:0], tbl_hi)
    cmd(PMTR_OP_WR_PCL, 9'h000, d[15:8]);
    `CHK("pcl busy", 1'h1, busy)
    `CHK("pcl dummy", 1'h0, fetch.valid)
    @(negedge i_clock);
    `CHK("pcl target", d[15:8], fetch.pc[7:0])
    a = 15'($urandom);
    TOOL.frame({1'h0, 1'h1, a, d}, rd);
    `CHK("ee addr", a, ee_q.addr)
    `CHK("ee data", d[7:0], ee_q.data)
    ee_rd = 8'($urandom);
    TOOL.frame({1'h1, 1'h1, a, 16'h0000}, rd);
    `CHK("ee read", {8'h00, ee_rd}, rd)
    // frame while programming is disabled must not land
    @(negedge i_clock);
    pen = 1'h0;
    TOOL.frame({1'h0, 1'h0, 15'h7fff, ~mem[15'h7fff]}, rd);
    @(negedge i_clock);
    pen = 1'h1;
    TOOL.frame({1'h1, 1'h0, 15'h7fff, 16'h0000}, rd);
    `CHK("refused write", mem[15'h7fff], rd)
    // second reset in mid-run restarts at the vector
    @(negedge i_clock);
    i_reset_n = 1'h0;
    @(negedge i_clock);
    i_reset_n = 1'h1;
    @(negedge i_clock);
    `CHK("restart pc", 15'h0000, fetch.pc)
    `CHK("restart fetch", 1'h1, fetch.valid)
    `CHK("restart word", mem[15'h0000], fetch.word)
    end_of_test();
  end
endmodule : pmtr_top_tb
`default_nettype wire
